// >>> iys_pkg.sv
// Purpose: Shared types and constants for the indexed-Y bus cycle sequencer.
// Assumes: 16-bit address bus, 8-bit data bus, one bus cycle per clock.
// Notes:   Every cycle count and code used by the sequencer lives here.
package iys_pkg;

  // Instruction groups, each with its own bus cycle pattern
  typedef enum logic [3:0] {
    GRP_JUMP    = 4'h0, // Jump, no operand access
    GRP_READ8   = 4'h1, // Accumulator arithmetic, logic, compare, load
    GRP_RMW     = 4'h2, // Shift, rotate, clear, invert, inc, dec, negate
    GRP_TEST    = 4'h3, // Memory test, read only
    GRP_STORE8  = 4'h4, // Single accumulator store
    GRP_LOAD16  = 4'h5, // Sixteen-bit register load
    GRP_STORE16 = 4'h6, // Sixteen-bit register store
    GRP_ARITH16 = 4'h7, // Sixteen-bit add, subtract, compare
    GRP_CALL    = 4'h8, // Subroutine call
    GRP_BITOP   = 4'h9, // Set or clear bits in memory
    GRP_BRBIT   = 4'ha  // Branch on bits set or clear
  } iys_group_t;

  // Sequencer states; the code equals the bus cycle number
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_C1 = 4'h1,
    ST_C2 = 4'h2,
    ST_C3 = 4'h3,
    ST_C4 = 4'h4,
    ST_C5 = 4'h5,
    ST_C6 = 4'h6,
    ST_C7 = 4'h7,
    ST_C8 = 4'h8
  } iys_state_t;

  // Sources of the address driven in a bus cycle
  typedef enum logic [3:0] {
    AK_PC0 = 4'h0, // Opcode address
    AK_PC1 = 4'h1, // Opcode address + 1
    AK_PC2 = 4'h2, // Opcode address + 2
    AK_PC3 = 4'h3, // Opcode address + 3
    AK_PC4 = 4'h4, // Opcode address + 4
    AK_ONES = 4'h5, // Dummy cycle address
    AK_EA = 4'h6, // Index Y plus offset
    AK_EA1 = 4'h7, // Index Y plus offset plus one
    AK_SP = 4'h8, // Stack pointer
    AK_SP1 = 4'h9 // Stack pointer minus one
  } iys_addr_kind_t;

  // Opcode bytes checked by the sequencer
  localparam logic [7:0] PAGE_PREBYTE = 8'h18;
  localparam logic [7:0] OPC_JUMP = 8'h6e;
  localparam logic [7:0] OPC_TEST = 8'h6d;
  localparam logic [7:0] OPC_CALL = 8'had;

  // Bus values in dummy cycles and while idle or in reset
  localparam logic [15:0] DUMMY_ADDR = 16'hffff;
  localparam logic [15:0] IDLE_ADDR = 16'hffff;
  localparam logic IDLE_RW = 1'b1;
  localparam logic [7:0] IDLE_DATA = 8'h00;

  // Cycles per group
  localparam logic [3:0] LEN_JUMP = 4'h4;
  localparam logic [3:0] LEN_SHORT = 4'h5; // Byte read and byte store
  localparam logic [3:0] LEN_WORD = 4'h6; // Sixteen-bit load and store
  localparam logic [3:0] LEN_LONG = 4'h7; // Modify, test, word arith, call
  localparam logic [3:0] LEN_BITS = 4'h8; // Bit ops and bit branches

  // Request from the core, latched when the sequence starts
  typedef struct packed {
    iys_group_t group;
    logic [15:0] opcode_addr;
    logic [15:0] index_register_y;
    logic [15:0] stack_ptr;
    logic [7:0] acc_data;
    logic [15:0] reg_data;
    logic [15:0] ret_addr;
  } iys_req_t;

  // One bus cycle as driven onto the bus
  typedef struct packed {
    logic [15:0] addr;
    logic rw;
    logic [7:0] data_out;
  } iys_bus_t;

  // Bytes gathered from the bus during a sequence
  typedef struct packed {
    logic [7:0] prebyte;
    logic [7:0] opcode2;
    logic [7:0] offset;
    logic [7:0] operand_hi;
    logic [7:0] operand_lo;
    logic [7:0] mask;
    logic [7:0] branch_offset;
  } iys_capt_t;

endpackage : iys_pkg

// >>> iys_sequencer.sv
// Purpose: Bus cycle sequencer for indexed-Y addressing instructions.
// Assumes: Bus read data returns in the same cycle as its address.
// Notes:   Bus outputs are registered; state code equals the cycle number.
`timescale 1ns/1ps
module iys_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input iys_pkg::iys_req_t req,
  output logic ready,
  input wire logic [7:0] data_in,
  output iys_pkg::iys_bus_t bus,
  output iys_pkg::iys_capt_t capt,
  output logic [3:0] cycle_num,
  output logic done,
  output logic prebyte_bad,
  input wire logic [7:0] result_data
);

  // Sequencer state and its next value
  iys_pkg::iys_state_t st_reg;
  iys_pkg::iys_state_t st_next;
  // Latched request and the group as resolved from the second opcode
  iys_pkg::iys_req_t req_reg;
  iys_pkg::iys_group_t group_reg;
  iys_pkg::iys_group_t group_resolved;
  // Registered bus and its next value
  iys_pkg::iys_bus_t bus_reg;
  iys_pkg::iys_bus_t bus_next;
  // Captured bytes
  iys_pkg::iys_capt_t capt_reg;
  // Completion and prebyte error flags
  logic done_reg;
  logic prebyte_bad_reg;

  // Cycle count of a group
  function automatic logic [3:0] len_of(input iys_pkg::iys_group_t g);
    case (g)
      iys_pkg::GRP_JUMP: len_of = iys_pkg::LEN_JUMP;
      iys_pkg::GRP_READ8, iys_pkg::GRP_STORE8: len_of = iys_pkg::LEN_SHORT;
      iys_pkg::GRP_LOAD16, iys_pkg::GRP_STORE16: len_of = iys_pkg::LEN_WORD;
      iys_pkg::GRP_BITOP, iys_pkg::GRP_BRBIT: len_of = iys_pkg::LEN_BITS;
      default: len_of = iys_pkg::LEN_LONG;
    endcase
  endfunction : len_of

  // Address source of a bus cycle
  function automatic iys_pkg::iys_addr_kind_t kind_of(input iys_pkg::iys_group_t g,
                                                       input logic [3:0] c);
    kind_of = iys_pkg::AK_ONES;
    case (c)
      4'h1: kind_of = iys_pkg::AK_PC0;
      4'h2: kind_of = iys_pkg::AK_PC1;
      4'h3: kind_of = iys_pkg::AK_PC2;
      4'h4: kind_of = iys_pkg::AK_ONES;
      4'h5: kind_of = iys_pkg::AK_EA;
      4'h6: begin
        case (g)
          iys_pkg::GRP_LOAD16, iys_pkg::GRP_STORE16,
          iys_pkg::GRP_ARITH16: kind_of = iys_pkg::AK_EA1;
          iys_pkg::GRP_CALL: kind_of = iys_pkg::AK_SP;
          iys_pkg::GRP_BITOP, iys_pkg::GRP_BRBIT: kind_of = iys_pkg::AK_PC3;
          default: kind_of = iys_pkg::AK_ONES;
        endcase
      end
      4'h7: begin
        case (g)
          iys_pkg::GRP_RMW: kind_of = iys_pkg::AK_EA;
          iys_pkg::GRP_CALL: kind_of = iys_pkg::AK_SP1;
          iys_pkg::GRP_BRBIT: kind_of = iys_pkg::AK_PC4;
          default: kind_of = iys_pkg::AK_ONES;
        endcase
      end
      4'h8: begin
        // Bit ops write back; bit branches end on a dummy read
        if (g == iys_pkg::GRP_BITOP) begin
          kind_of = iys_pkg::AK_EA;
        end else begin
          kind_of = iys_pkg::AK_ONES;
        end
      end
      default: kind_of = iys_pkg::AK_ONES;
    endcase
  endfunction : kind_of

  // Whether a bus cycle writes
  function automatic logic wr_of(input iys_pkg::iys_group_t g, input logic [3:0] c);
    case (g)
      iys_pkg::GRP_STORE8: wr_of = (c == 4'h5);
      iys_pkg::GRP_RMW: wr_of = (c == 4'h7);
      iys_pkg::GRP_STORE16: wr_of = (c == 4'h5) || (c == 4'h6);
      iys_pkg::GRP_CALL: wr_of = (c == 4'h6) || (c == 4'h7);
      iys_pkg::GRP_BITOP: wr_of = (c == 4'h8);
      default: wr_of = 1'b0;
    endcase
  endfunction : wr_of

  // Decoded view of the current and next cycle
  wire logic idle = (st_reg == iys_pkg::ST_IDLE);
  wire logic is_last = (st_reg == len_of(group_reg));
  wire logic [3:0] cyc_next = st_next;
  // Request source: live while idle, latched during the sequence
  wire iys_pkg::iys_req_t req_src = idle ? req : req_reg;
  // Effective address, wraps modulo 65536
  wire logic [15:0] eff_addr = 16'(req_reg.index_register_y + {8'h00, capt_reg.offset});
  wire logic [15:0] eff_addr1 = 16'(eff_addr + 16'h0001);
  wire logic [15:0] pc = req_src.opcode_addr;
  wire iys_pkg::iys_addr_kind_t kind_next = kind_of(group_reg, cyc_next);
  wire logic wr_next = (st_next != iys_pkg::ST_IDLE) && wr_of(group_reg, cyc_next);

  // Second opcode byte overrides the group for jump, test and call
  assign group_resolved = (data_in == iys_pkg::OPC_JUMP) ? iys_pkg::GRP_JUMP :
                          (data_in == iys_pkg::OPC_TEST) ? iys_pkg::GRP_TEST :
                          (data_in == iys_pkg::OPC_CALL) ? iys_pkg::GRP_CALL :
                          req_reg.group;

  // Next state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      iys_pkg::ST_IDLE: begin
        if (start) begin
          st_next = iys_pkg::ST_C1;
        end
      end
      iys_pkg::ST_C8: st_next = iys_pkg::ST_IDLE;
      default: begin
        // Jump ends after cycle four, others at their own length
        st_next = is_last ? iys_pkg::ST_IDLE : iys_pkg::iys_state_t'(st_reg + 4'h1);
      end
    endcase
  end

  // Address selection for the next bus cycle
  wire logic [15:0] addr_sel =
    (kind_next == iys_pkg::AK_PC0) ? pc :
    (kind_next == iys_pkg::AK_PC1) ? 16'(pc + 16'h0001) :
    (kind_next == iys_pkg::AK_PC2) ? 16'(pc + 16'h0002) :
    (kind_next == iys_pkg::AK_PC3) ? 16'(pc + 16'h0003) :
    (kind_next == iys_pkg::AK_PC4) ? 16'(pc + 16'h0004) :
    (kind_next == iys_pkg::AK_EA) ? eff_addr :
    (kind_next == iys_pkg::AK_EA1) ? eff_addr1 :
    (kind_next == iys_pkg::AK_SP) ? req_reg.stack_ptr :
    (kind_next == iys_pkg::AK_SP1) ? 16'(req_reg.stack_ptr - 16'h0001) :
    iys_pkg::DUMMY_ADDR;

  // Write data selection for the next bus cycle
  wire logic [7:0] wdata_sel =
    (group_reg == iys_pkg::GRP_STORE8) ? req_reg.acc_data :
    (group_reg == iys_pkg::GRP_STORE16 && cyc_next == 4'h5) ? req_reg.reg_data[15:8] :
    (group_reg == iys_pkg::GRP_STORE16) ? req_reg.reg_data[7:0] :
    (group_reg == iys_pkg::GRP_CALL && cyc_next == 4'h6) ? req_reg.ret_addr[7:0] :
    (group_reg == iys_pkg::GRP_CALL) ? req_reg.ret_addr[15:8] :
    result_data;

  // Next bus cycle; idle bus reads the all-ones address
  always_comb begin
    bus_next.addr = iys_pkg::IDLE_ADDR;
    bus_next.rw = iys_pkg::IDLE_RW;
    bus_next.data_out = iys_pkg::IDLE_DATA;
    if (st_next != iys_pkg::ST_IDLE) begin
      bus_next.addr = addr_sel;
      bus_next.rw = !wr_next;
      bus_next.data_out = wr_next ? wdata_sel : iys_pkg::IDLE_DATA;
    end
  end

  // Capture enables, qualified by the cycle on the bus now
  wire logic rd_now = bus_reg.rw && !idle;
  wire logic cap_hi = rd_now && (st_reg == iys_pkg::ST_C5);
  wire logic word_grp = (group_reg == iys_pkg::GRP_LOAD16) ||
                        (group_reg == iys_pkg::GRP_ARITH16);
  wire logic bit_grp = (group_reg == iys_pkg::GRP_BITOP) ||
                       (group_reg == iys_pkg::GRP_BRBIT);
  wire logic cap_lo = rd_now && (st_reg == iys_pkg::ST_C6) && word_grp;
  wire logic cap_mask = rd_now && (st_reg == iys_pkg::ST_C6) && bit_grp;
  wire logic cap_br = (st_reg == iys_pkg::ST_C7) && (group_reg == iys_pkg::GRP_BRBIT);

  // State, bus and done registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= iys_pkg::ST_IDLE;
      bus_reg <= {iys_pkg::IDLE_ADDR, iys_pkg::IDLE_RW, iys_pkg::IDLE_DATA};
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      bus_reg <= bus_next;
      done_reg <= !idle && (st_next == iys_pkg::ST_IDLE);
    end
  end

  // Request latch and group resolution
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_reg <= '0;
      group_reg <= iys_pkg::GRP_JUMP;
    end else if (idle && start) begin
      req_reg <= req;
      group_reg <= req.group;
    end else if (st_reg == iys_pkg::ST_C2) begin
      group_reg <= group_resolved;
    end
  end

  // Prefetch, operand, mask and branch offset captures and prebyte check
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capt_reg <= '0;
      prebyte_bad_reg <= 1'b0;
    end else begin
      if (idle && start) begin
        prebyte_bad_reg <= 1'b0;
      end
      if (st_reg == iys_pkg::ST_C1) begin
        capt_reg.prebyte <= data_in;
        prebyte_bad_reg <= (data_in != iys_pkg::PAGE_PREBYTE);
      end
      if (st_reg == iys_pkg::ST_C2) begin
        capt_reg.opcode2 <= data_in;
      end
      if (st_reg == iys_pkg::ST_C3) begin
        capt_reg.offset <= data_in;
      end
      if (cap_hi) begin
        capt_reg.operand_hi <= data_in;
      end
      if (cap_lo) begin
        capt_reg.operand_lo <= data_in;
      end
      if (cap_mask) begin
        capt_reg.mask <= data_in;
      end
      if (cap_br) begin
        capt_reg.branch_offset <= data_in;
      end
    end
  end

  // Outputs
  assign ready = idle;
  assign bus = bus_reg;
  assign capt = capt_reg;
  assign cycle_num = st_reg;
  assign done = done_reg;
  assign prebyte_bad = prebyte_bad_reg;

  // Checks on the driven bus
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_prefetch_addrs: assert property (
    (ready && start) |=> (bus.addr == req_reg.opcode_addr && bus.rw)
      ##1 (bus.addr == 16'(req_reg.opcode_addr + 16'h0001) && bus.rw)
      ##1 (bus.addr == 16'(req_reg.opcode_addr + 16'h0002) && bus.rw))
    else $error("prefetch addresses wrong");
  a_dummy_cycle4: assert property (
    (cycle_num == 4'h3) |=> (cycle_num == 4'h4 && bus.addr == 16'hffff && bus.rw))
    else $error("cycle four not a dummy read");
  a_jump_length: assert property (
    (cycle_num == 4'h4 && group_reg == iys_pkg::GRP_JUMP) |=> (cycle_num == 4'h0 && done))
    else $error("jump not four cycles");
  a_read8_operand: assert property (
    (cycle_num == 4'h5 && group_reg == iys_pkg::GRP_READ8) |-> bus.rw ##1 cycle_num == 4'h0)
    else $error("byte read sequence wrong");
  a_rmw_writeback: assert property (
    (cycle_num == 4'h5 && group_reg == iys_pkg::GRP_RMW) |-> bus.rw
      ##1 (bus.addr == 16'hffff && bus.rw) ##1 (!bus.rw && bus.addr == $past(bus.addr, 2)))
    else $error("modify write back wrong");
  a_test_no_write: assert property (
    (cycle_num == 4'h5 && group_reg == iys_pkg::GRP_TEST) |-> bus.rw
      ##1 (bus.addr == 16'hffff && bus.rw) [*2] ##1 cycle_num == 4'h0)
    else $error("test sequence wrong");
  a_store8_data: assert property (
    (cycle_num == 4'h5 && group_reg == iys_pkg::GRP_STORE8) |-> (!bus.rw && bus.data_out == req_reg.acc_data))
    else $error("byte store wrong");
  a_load16_pair: assert property (
    (cycle_num == 4'h5 && group_reg == iys_pkg::GRP_LOAD16) |-> bus.rw
      ##1 (bus.rw && bus.addr == 16'($past(bus.addr) + 16'h0001)) ##1 cycle_num == 4'h0)
    else $error("word load wrong");
  a_store16_pair: assert property (
    (cycle_num == 4'h5 && group_reg == iys_pkg::GRP_STORE16) |-> (!bus.rw && bus.data_out == req_reg.reg_data[15:8])
      ##1 (!bus.rw && bus.data_out == req_reg.reg_data[7:0]))
    else $error("word store wrong");
  a_arith16_dummy: assert property (
    (cycle_num == 4'h6 && group_reg == iys_pkg::GRP_ARITH16) |=> (bus.addr == 16'hffff && bus.rw) ##1 cycle_num == 4'h0)
    else $error("word arithmetic tail wrong");
  a_call_push: assert property (
    (cycle_num == 4'h5 && group_reg == iys_pkg::GRP_CALL) |-> bus.rw
      ##1 (!bus.rw && bus.addr == req_reg.stack_ptr && bus.data_out == req_reg.ret_addr[7:0])
      ##1 (!bus.rw && bus.data_out == req_reg.ret_addr[15:8]))
    else $error("call push wrong");
  a_bitop_mask: assert property (
    (cycle_num == 4'h6 && group_reg == iys_pkg::GRP_BITOP) |->
      (bus.addr == 16'(req_reg.opcode_addr + 16'h0003)) ##2 (!bus.rw && cycle_num == 4'h8))
    else $error("bit op sequence wrong");
  a_brbit_offset: assert property (
    (cycle_num == 4'h7 && group_reg == iys_pkg::GRP_BRBIT) |->
      (bus.addr == 16'(req_reg.opcode_addr + 16'h0004) && bus.rw) ##1 (bus.addr == 16'hffff && bus.rw))
    else $error("bit branch sequence wrong");
  a_ea_wrap: assert property (
    (cycle_num == 4'h5) |-> bus.addr == 16'(req_reg.index_register_y + {8'h00, capt.offset}))
    else $error("effective address wrong");
  a_rw_low_only: assert property (
    !bus.rw |-> (cycle_num >= 4'h5 && (group_reg inside {iys_pkg::GRP_STORE8, iys_pkg::GRP_RMW,
      iys_pkg::GRP_STORE16, iys_pkg::GRP_CALL, iys_pkg::GRP_BITOP})))
    else $error("write outside a write cycle");

  c_jump_done: cover property (cycle_num == 4'h4 && group_reg == iys_pkg::GRP_JUMP ##1 done);
  c_call_done: cover property (cycle_num == 4'h7 && group_reg == iys_pkg::GRP_CALL);
  c_bitop_done: cover property (cycle_num == 4'h8 && group_reg == iys_pkg::GRP_BITOP);
  c_store16_hi: cover property (cycle_num == 4'h5 && group_reg == iys_pkg::GRP_STORE16);

endmodule : iys_sequencer

// >>> iys_mem_model.sv
// Purpose: Byte memory on the far side of the sequencer bus.
// Assumes: A read answers in the same cycle its address is shown.
// Notes: Write cycles show the inverse of the last byte read, never stale data.
`timescale 1ns/1ps
module iys_mem_model (
  input wire logic clk,
  input iys_pkg::iys_bus_t bus,
  output logic [7:0] data_in
);
  logic [7:0] mem [0:65535]; // Byte storage, preloaded by the bench
  logic [7:0] last_reg; // Last byte handed out on a read

  // Read path; bus not read, so drive a changed value
  assign data_in = bus.rw ? mem[bus.addr] : ~last_reg;

  // Write capture and read history; plain always, since the bench also preloads mem
  always @(posedge clk) begin
    if (bus.rw) begin
      last_reg <= mem[bus.addr];
    end else begin
      mem[bus.addr] <= bus.data_out;
    end
  end
endmodule : iys_mem_model

// >>> tb_top.sv
// Purpose: Self-checking bench for the indexed-Y bus cycle sequencer.
// Assumes: Memory model answers reads at once; one sequence at a time.
// Notes: Each scenario except the two reset checks traces every bus cycle against a hand-built list.
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, start, ready, done, prebyte_bad;
  iys_pkg::iys_req_t req; // Request to the sequencer
  iys_pkg::iys_req_t r; // Next request, staged between edges
  logic [7:0] data_in, result_data, res;
  iys_pkg::iys_bus_t bus;
  iys_pkg::iys_capt_t capt;
  logic [3:0] cycle_num;
  int num_errors, check_count, n;
  logic [15:0] e_addr [1:8]; // Expected address per cycle
  logic e_rw [1:8]; // Expected read/write level
  logic [7:0] e_dat [1:8]; // Expected write data
  logic [15:0] pc, ea; // Opcode and effective address
  logic [7:0] e_pre, e_off, e_op2; // Prebyte, offset and second opcode placed in memory

  iys_sequencer i_dut (.clk(clk), .rst(rst), .start(start), .req(req), .ready(ready),
    .data_in(data_in), .bus(bus), .capt(capt), .cycle_num(cycle_num), .done(done),
    .prebyte_bad(prebyte_bad), .result_data(result_data));
  iys_mem_model i_mem (.clk(clk), .bus(bus), .data_in(data_in));

  // Free-running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic stop_test;
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // Single comparison point
  task automatic check(input logic [15:0] seen, input logic [15:0] expv, input string what);
    check_count++;
    if (seen !== expv) begin
      num_errors++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask : check

  // One expected bus cycle
  task automatic ex(input int c, input logic [15:0] a, input logic w, input logic [7:0] d);
    e_addr[c] = a;
    e_rw[c] = w;
    e_dat[c] = d;
  endtask : ex

  // Preload the three fetch bytes and the common cycles 1 to 4
  task automatic prep(input iys_pkg::iys_group_t g, input logic [7:0] op2, input logic [7:0] pre,
    input logic [15:0] p, input logic [15:0] iy, input logic [7:0] off);
    pc = p;
    ea = iy + {8'h00, off};
    e_pre = pre;
    e_off = off;
    e_op2 = op2;
    i_mem.mem[p] = pre;
    i_mem.mem[p + 16'h1] = op2;
    i_mem.mem[p + 16'h2] = off;
    r.group = g;
    r.opcode_addr = p;
    r.index_register_y = iy;
    ex(1, p, 1'b1, 8'h00);
    ex(2, p + 16'h1, 1'b1, 8'h00);
    ex(3, p + 16'h2, 1'b1, 8'h00);
    ex(4, 16'hffff, 1'b1, 8'h00);
  endtask : prep

  // Start a sequence, trace each bus cycle until done; hold keeps start up through cycle three
  task automatic go(input logic hold, output int cnt);
    cnt = 0;
    @(posedge clk);
    start <= 1'b1;
    req <= r;
    result_data <= res;
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      start <= hold && (cnt < 3);
      #1;
      if (done === 1'b1) break;
      cnt++;
      check(16'(cycle_num), 16'(cnt), "cycle number");
      check(16'(ready), 16'h0000, "busy ready");
      check(bus.addr, e_addr[cnt], "address");
      check(16'(bus.rw), 16'(e_rw[cnt]), "read write level");
      if (e_rw[cnt] === 1'b0) check(16'(bus.data_out), 16'(e_dat[cnt]), "write data");
    end
    if (done !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t sequence never completed", $time);
      stop_test();
    end else begin
      check(16'(capt.offset), 16'(e_off), "offset capture");
      check(16'(capt.opcode2), 16'(e_op2), "second opcode capture");
      check(16'(capt.prebyte), 16'(e_pre), "prebyte capture");
      check(16'(prebyte_bad), 16'(e_pre !== iys_pkg::PAGE_PREBYTE), "prebyte flag");
    end
  endtask : go

  // Idle bus after reset
  task automatic t_reset;
    check(bus.addr, 16'hffff, "idle address");
    check(16'(bus.rw), 16'h0001, "idle read write");
    check(16'(ready), 16'h0001, "idle ready");
  endtask : t_reset

  // Reset in mid-sequence drops the bus to idle and clears captures
  task automatic t_midreset;
    prep(iys_pkg::GRP_STORE8, 8'ha7, 8'h1a, 16'h4b00, 16'h0d00, 8'h09);
    @(posedge clk);
    start <= 1'b1;
    req <= r;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    check(bus.addr, 16'hffff, "reset address");
    check(16'(bus.rw), 16'h0001, "reset read write");
    check(16'(cycle_num), 16'h0000, "reset cycle number");
    check(16'(ready), 16'h0001, "reset ready");
    check(16'(done), 16'h0000, "reset done");
    check(16'(prebyte_bad), 16'h0000, "reset prebyte flag");
    check(16'(capt.prebyte), 16'h0000, "reset prebyte capture");
    @(posedge clk);
    rst <= 1'b0;
  endtask : t_midreset

  // Wrong prebyte is flagged, byte read still runs
  task automatic t_badpre;
    prep(iys_pkg::GRP_READ8, 8'ha6, 8'h1a, 16'h3000, 16'h2000, 8'h05);
    ex(5, ea, 1'b1, 8'h00);
    go(1'b0, n);
    check(16'(n), 16'h0005, "byte read length");
  endtask : t_badpre

  // Jump forced by second byte over a byte-read group
  task automatic t_jump;
    prep(iys_pkg::GRP_READ8, iys_pkg::OPC_JUMP, 8'h18, 16'h4000, 16'h1000, 8'h10);
    go(1'b0, n);
    check(16'(n), 16'h0004, "jump length");
  endtask : t_jump

  // Byte read with effective address wrapping past zero
  task automatic t_read8;
    prep(iys_pkg::GRP_READ8, 8'ha6, 8'h18, 16'h4100, 16'hfff0, 8'h20);
    i_mem.mem[ea] = 8'h77;
    ex(5, ea, 1'b1, 8'h00);
    go(1'b0, n);
    check(16'(n), 16'h0005, "byte read length");
    check(16'(capt.operand_hi), 16'h0077, "operand capture");
  endtask : t_read8

  // Modify: read, dummy, write back result
  task automatic t_rmw;
    prep(iys_pkg::GRP_RMW, 8'h68, 8'h18, 16'h4200, 16'h0500, 8'h80);
    res = 8'h99;
    ex(5, ea, 1'b1, 8'h00);
    ex(6, 16'hffff, 1'b1, 8'h00);
    ex(7, ea, 1'b0, 8'h99);
    go(1'b0, n);
    check(16'(n), 16'h0007, "modify length");
    check(16'(i_mem.mem[ea]), 16'h0099, "modify result in memory");
  endtask : t_rmw

  // Memory test forced by second byte, two dummies, no write
  task automatic t_test;
    prep(iys_pkg::GRP_RMW, iys_pkg::OPC_TEST, 8'h18, 16'h4300, 16'h0600, 8'h01);
    ex(5, ea, 1'b1, 8'h00);
    ex(6, 16'hffff, 1'b1, 8'h00);
    ex(7, 16'hffff, 1'b1, 8'h00);
    go(1'b0, n);
    check(16'(n), 16'h0007, "test length");
  endtask : t_test

  // Byte store with start held high through the first three busy cycles
  task automatic t_store8;
    prep(iys_pkg::GRP_STORE8, 8'ha7, 8'h18, 16'h4400, 16'h0700, 8'h02);
    ex(5, ea, 1'b0, 8'hc3);
    go(1'b1, n);
    check(16'(n), 16'h0005, "byte store length");
  endtask : t_store8

  // Word load, low byte address wraps to zero
  task automatic t_load16;
    prep(iys_pkg::GRP_LOAD16, 8'hec, 8'h18, 16'h4500, 16'hff00, 8'hff);
    i_mem.mem[16'h0000] = 8'h5e;
    ex(5, ea, 1'b1, 8'h00);
    ex(6, ea + 16'h1, 1'b1, 8'h00);
    go(1'b0, n);
    check(16'(n), 16'h0006, "word load length");
    check({capt.operand_hi, capt.operand_lo}, 16'h3c5e, "word capture");
  endtask : t_load16

  // Word store, high byte first
  task automatic t_store16;
    prep(iys_pkg::GRP_STORE16, 8'hed, 8'h18, 16'h4600, 16'h0800, 8'h03);
    ex(5, ea, 1'b0, 8'hbe);
    ex(6, ea + 16'h1, 1'b0, 8'h5a);
    go(1'b0, n);
    check(16'(n), 16'h0006, "word store length");
  endtask : t_store16

  // Word arithmetic ends in a dummy read
  task automatic t_arith16;
    prep(iys_pkg::GRP_ARITH16, 8'ha3, 8'h18, 16'h4700, 16'h0900, 8'h04);
    ex(5, ea, 1'b1, 8'h00);
    ex(6, ea + 16'h1, 1'b1, 8'h00);
    ex(7, 16'hffff, 1'b1, 8'h00);
    go(1'b0, n);
    check(16'(n), 16'h0007, "word arith length");
  endtask : t_arith16

  // Call forced by second byte, pushes return address
  task automatic t_call;
    prep(iys_pkg::GRP_READ8, iys_pkg::OPC_CALL, 8'h18, 16'h4800, 16'h0a00, 8'h06);
    ex(5, ea, 1'b1, 8'h00);
    ex(6, 16'h01ff, 1'b0, 8'h34);
    ex(7, 16'h01fe, 1'b0, 8'h12);
    go(1'b0, n);
    check(16'(n), 16'h0007, "call length");
    check(16'(i_mem.mem[16'h01fe]), 16'h0012, "pushed high byte");
  endtask : t_call

  // Bit set or clear: operand, mask, dummy, write
  task automatic t_bitop;
    prep(iys_pkg::GRP_BITOP, 8'h1c, 8'h18, 16'h4900, 16'h0b00, 8'h07);
    i_mem.mem[pc + 16'h3] = 8'h0f;
    res = 8'h42;
    ex(5, ea, 1'b1, 8'h00);
    ex(6, pc + 16'h3, 1'b1, 8'h00);
    ex(7, 16'hffff, 1'b1, 8'h00);
    ex(8, ea, 1'b0, 8'h42);
    go(1'b0, n);
    check(16'(n), 16'h0008, "bit op length");
    check(16'(capt.mask), 16'h000f, "mask capture");
  endtask : t_bitop

  // Branch on bits: operand, mask, offset, dummy
  task automatic t_brbit;
    prep(iys_pkg::GRP_BRBIT, 8'h1e, 8'h18, 16'h4a00, 16'h0c00, 8'h08);
    i_mem.mem[pc + 16'h3] = 8'hf0;
    i_mem.mem[pc + 16'h4] = 8'hfe;
    ex(5, ea, 1'b1, 8'h00);
    ex(6, pc + 16'h3, 1'b1, 8'h00);
    ex(7, pc + 16'h4, 1'b1, 8'h00);
    ex(8, 16'hffff, 1'b1, 8'h00);
    go(1'b0, n);
    check(16'(n), 16'h0008, "bit branch length");
    check(16'(capt.branch_offset), 16'h00fe, "branch offset capture");
  endtask : t_brbit

  // Main sequence
  initial begin
    num_errors = 0;
    check_count = 0;
    rst = 1'b1;
    start = 1'b0;
    req = '0;
    r = '0;
    r.stack_ptr = 16'h01ff;
    r.acc_data = 8'hc3;
    r.reg_data = 16'hbe5a;
    r.ret_addr = 16'h1234;
    res = 8'h00;
    result_data = 8'h00;
    i_mem.mem[16'hffff] = 8'h3c;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_badpre();
    t_midreset();
    t_jump();
    t_read8();
    t_rmw();
    t_test();
    t_store8();
    t_load16();
    t_store16();
    t_arith16();
    t_call();
    t_bitop();
    t_brbit();
    stop_test();
  end
endmodule : tb_top
